//--- core/cel_cfg.svh
// constants for the exception entry logic
`ifndef CEL_CFG_SVH
`define CEL_CFG_SVH

// ********************
// status word fields
// ********************
`define CEL_SR_D        27
`define CEL_SR_DM       26
`define CEL_SR_J        25
`define CEL_SR_MODE_HI  24
`define CEL_SR_MODE_LO  22
`define CEL_SR_EM       21
`define CEL_SR_I3M      20
`define CEL_SR_I2M      19
`define CEL_SR_I1M      18
`define CEL_SR_I0M      17
`define CEL_SR_GM       16
`define CEL_SR_R        15
`define CEL_SR_RESET    32'h0021_0000

// ********************
// mode values
// ********************
`define CEL_MODE_EXC    3'h6
`define CEL_MODE_NMI    3'h7
`define CEL_MODE_L3     3'h5
`define CEL_MODE_L2     3'h4
`define CEL_MODE_L1     3'h3
`define CEL_MODE_L0     3'h2

// ********************
// vector offsets
// ********************
`define CEL_VEC_UNREC   32'h0000_0000
`define CEL_VEC_DBUS    32'h0000_0008
`define CEL_VEC_IBUS    32'h0000_000c
`define CEL_VEC_NMI     32'h0000_0010
`define CEL_VEC_IADDR   32'h0000_0014
`define CEL_VEC_IPROT   32'h0000_0018
`define CEL_VEC_BKPT    32'h0000_001c
`define CEL_VEC_ILL     32'h0000_0020
`define CEL_VEC_UNIMPL  32'h0000_0024
`define CEL_VEC_DREAD   32'h0000_0034
`define CEL_VEC_IMISS   32'h0000_0050

// ********************
// instruction event bits
// ********************
`define CEL_IE_W        8
`define CEL_IE_IBUS     0
`define CEL_IE_IADDR    1
`define CEL_IE_IMISS    2
`define CEL_IE_IPROT    3
`define CEL_IE_BKPT     4
`define CEL_IE_ILL      5
`define CEL_IE_UNIMPL   6
`define CEL_IE_DREAD    7

// ********************
// fault page register
// ********************
`define CEL_PG_LSB      10
`define CEL_PG_ISIDE    8

// ********************
// register word indices and save slots
// ********************
`define CEL_REG_STATUS  5'h00
`define CEL_REG_VBASE   5'h01
`define CEL_REG_FVADDR  5'h02
`define CEL_REG_FPAGE   5'h03
`define CEL_REG_SAVE0   5'h04
`define CEL_REG_LAST    5'h11
`define CEL_SLOTS       7
`define CEL_SLOT_EXC    3'h0
`define CEL_SLOT_NMI    3'h1
`define CEL_SLOT_L3     3'h2
`define CEL_SLOT_L2     3'h3
`define CEL_SLOT_L1     3'h4
`define CEL_SLOT_L0     3'h5
`define CEL_SLOT_DBG    3'h6

`endif

//--- core/cel_pkg.sv
// types for the exception entry logic
package cel_pkg;
  typedef enum logic [4:0] {
    EV_NONE, EV_UNREC, EV_DBUS, EV_IBUS, EV_NMI, EV_IRQ_LEVEL3, EV_IRQ_LEVEL2, EV_IRQ_LEVEL1, EV_IRQ_LEVEL0,
    EV_IADDR, EV_IMISS, EV_IPROT, EV_BKPT, EV_ILL, EV_UNIMPL, EV_DREAD
  } cel_evt_t;
endpackage

//--- core/cel_exc_entry.sv
// exception and interrupt entry logic with register access
`timescale 1ns/10ps
`default_nettype none
`include "cel_cfg.svh"

module cel_exc_entry
  import cel_pkg::*;
(
  // clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 rst_n,
  // avalon-mm slave
  input  wire logic [4:0]           avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  output logic      [31:0]          avs_readdata,
  output logic                      avs_waitrequest,
  // asynchronous event lines
  input  wire logic                 nmiReq,
  input  wire logic [3:0]           irqLevel,
  input  wire logic                 debugBreak,
  // interrupt controller offset
  input  wire logic [31:0]          irqOffset,
  // pipeline side
  input  wire logic                 instrBoundary,
  input  wire logic                 dataBusErr,
  input  wire logic [`CEL_IE_W-1:0] oldEvt,
  input  wire logic [`CEL_IE_W-1:0] youngEvt,
  input  wire logic [31:0]          offendPc,
  input  wire logic [31:0]          nextPc,
  input  wire logic [31:0]          failVaddr,
  input  wire logic                 debugReturn,
  // redirect to fetch
  output logic                      redirValid,
  output logic      [31:0]          redirAddr,
  output cel_evt_t                  entryCause,
  output logic      [31:0]          statusWord
);

  // ********************
  // reset release
  // ********************
  logic [1:0] rstSync;
  logic       rstN;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) rstSync <= 2'h0;
    else rstSync <= {rstSync[0], 1'b1};
  end
  assign rstN = rstSync[1];

  // ********************
  // input synchronisers
  // ********************
  // a change only counts once two later stages agree, so a runt pulse is dropped
  logic [5:0] sync1, sync2, sync3, filt, agree;
  assign agree = ~(sync2 ^ sync3);
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      sync1 <= 6'h00;
      sync2 <= 6'h00;
      sync3 <= 6'h00;
      filt  <= 6'h00;
    end else begin
      sync1 <= {debugBreak, nmiReq, irqLevel};
      sync2 <= sync1;
      sync3 <= sync2;
      filt  <= (filt & ~agree) | (sync3 & agree);
    end
  end

  logic       nmiF, brkF;
  logic [3:0] irqF;
  assign irqF = filt[3:0];
  assign nmiF = filt[4];
  assign brkF = filt[5];

  // ********************
  // registers
  // ********************
  logic [31:0] sr, vectorBase, faultVaddr, faultPage;
  logic [31:0] savedStatus [`CEL_SLOTS];
  logic [31:0] savedReturn [`CEL_SLOTS];
  logic [2:0]  mode;
  assign mode = sr[`CEL_SR_MODE_HI:`CEL_SR_MODE_LO];
  assign statusWord = sr;

  // ********************
  // event selection
  // ********************
  logic [`CEL_IE_W-1:0] ie;
  logic        take, excClass, faultRec, iSide, useOffset;
  cel_evt_t    kind;
  logic [2:0]  slot;
  logic [31:0] next_sr, vecOff, retAddr;

  always_comb begin
    // the oldest instruction wins even over higher priority younger events
    ie = (oldEvt != '0) ? oldEvt : youngEvt;
    kind = EV_NONE;
    if (instrBoundary) begin
      if (dataBusErr) kind = EV_DBUS;
      else if (ie[`CEL_IE_IBUS]) kind = EV_IBUS;
      else if (nmiF && mode != `CEL_MODE_NMI) kind = EV_NMI;
      else if (irqF[3] && !sr[`CEL_SR_GM] && !sr[`CEL_SR_I3M]) kind = EV_IRQ_LEVEL3;
      else if (irqF[2] && !sr[`CEL_SR_GM] && !sr[`CEL_SR_I2M]) kind = EV_IRQ_LEVEL2;
      else if (irqF[1] && !sr[`CEL_SR_GM] && !sr[`CEL_SR_I1M]) kind = EV_IRQ_LEVEL1;
      else if (irqF[0] && !sr[`CEL_SR_GM] && !sr[`CEL_SR_I0M]) kind = EV_IRQ_LEVEL0;
      else if (ie[`CEL_IE_IADDR]) kind = EV_IADDR;
      else if (ie[`CEL_IE_IMISS]) kind = EV_IMISS;
      else if (ie[`CEL_IE_IPROT]) kind = EV_IPROT;
      else if (ie[`CEL_IE_BKPT] || (brkF && !sr[`CEL_SR_DM])) kind = EV_BKPT;
      else if (ie[`CEL_IE_ILL]) kind = EV_ILL;
      else if (ie[`CEL_IE_UNIMPL]) kind = EV_UNIMPL;
      else if (ie[`CEL_IE_DREAD]) kind = EV_DREAD;
    end
    excClass = (kind == EV_DBUS) || (kind == EV_IBUS) || (kind == EV_IADDR) || (kind == EV_IMISS) ||
               (kind == EV_IPROT) || (kind == EV_ILL) || (kind == EV_UNIMPL) || (kind == EV_DREAD);
    if (excClass && sr[`CEL_SR_EM]) kind = EV_UNREC;
    take      = (kind != EV_NONE);
    next_sr   = sr;
    next_sr[`CEL_SR_R] = 1'b0;
    next_sr[`CEL_SR_J] = 1'b0;
    slot      = `CEL_SLOT_EXC;
    vecOff    = `CEL_VEC_UNREC;
    retAddr   = offendPc;
    faultRec  = 1'b0;
    iSide     = 1'b0;
    useOffset = 1'b0;
    unique case (kind)
      EV_UNREC, EV_IBUS, EV_ILL, EV_UNIMPL, EV_DREAD, EV_DBUS: begin
        next_sr[`CEL_SR_MODE_HI:`CEL_SR_MODE_LO] = `CEL_MODE_EXC;
        next_sr[`CEL_SR_EM] = 1'b1;
        next_sr[`CEL_SR_GM] = 1'b1;
        if (kind == EV_DBUS) begin
          vecOff  = `CEL_VEC_DBUS;
          retAddr = nextPc;
        end
        if (kind == EV_IBUS) vecOff = `CEL_VEC_IBUS;
        if (kind == EV_ILL) vecOff = `CEL_VEC_ILL;
        if (kind == EV_UNIMPL) vecOff = `CEL_VEC_UNIMPL;
        if (kind == EV_DREAD) begin
          vecOff   = `CEL_VEC_DREAD;
          faultRec = 1'b1;
        end
      end
      EV_NMI: begin
        slot    = `CEL_SLOT_NMI;
        retAddr = nextPc;
        vecOff  = `CEL_VEC_NMI;
        next_sr[`CEL_SR_MODE_HI:`CEL_SR_MODE_LO] = `CEL_MODE_NMI;
        next_sr[`CEL_SR_EM] = 1'b1;
        next_sr[`CEL_SR_GM] = 1'b1;
      end
      EV_IRQ_LEVEL3, EV_IRQ_LEVEL2, EV_IRQ_LEVEL1, EV_IRQ_LEVEL0: begin
        retAddr   = nextPc;
        useOffset = 1'b1;
        next_sr[`CEL_SR_I0M] = 1'b1;
        if (kind == EV_IRQ_LEVEL0) begin
          slot = `CEL_SLOT_L0;
          next_sr[`CEL_SR_MODE_HI:`CEL_SR_MODE_LO] = `CEL_MODE_L0;
        end
        if (kind != EV_IRQ_LEVEL0) next_sr[`CEL_SR_I1M] = 1'b1;
        if (kind == EV_IRQ_LEVEL1) begin
          slot = `CEL_SLOT_L1;
          next_sr[`CEL_SR_MODE_HI:`CEL_SR_MODE_LO] = `CEL_MODE_L1;
        end
        if (kind == EV_IRQ_LEVEL2 || kind == EV_IRQ_LEVEL3) next_sr[`CEL_SR_I2M] = 1'b1;
        if (kind == EV_IRQ_LEVEL2) begin
          slot = `CEL_SLOT_L2;
          next_sr[`CEL_SR_MODE_HI:`CEL_SR_MODE_LO] = `CEL_MODE_L2;
        end
        if (kind == EV_IRQ_LEVEL3) begin
          slot = `CEL_SLOT_L3;
          next_sr[`CEL_SR_I3M] = 1'b1;
          next_sr[`CEL_SR_MODE_HI:`CEL_SR_MODE_LO] = `CEL_MODE_L3;
        end
      end
      EV_IADDR, EV_IMISS, EV_IPROT: begin
        faultRec = 1'b1;
        iSide    = (kind != EV_IADDR);
        next_sr[`CEL_SR_MODE_HI:`CEL_SR_MODE_LO] = `CEL_MODE_EXC;
        next_sr[`CEL_SR_EM] = 1'b1;
        if (kind == EV_IADDR) vecOff = `CEL_VEC_IADDR;
        if (kind == EV_IMISS) vecOff = `CEL_VEC_IMISS;
        if (kind == EV_IPROT) vecOff = `CEL_VEC_IPROT;
      end
      EV_BKPT: begin
        slot   = `CEL_SLOT_DBG;
        vecOff = `CEL_VEC_BKPT;
        next_sr[`CEL_SR_MODE_HI:`CEL_SR_MODE_LO] = `CEL_MODE_EXC;
        next_sr[`CEL_SR_D]  = 1'b1;
        next_sr[`CEL_SR_DM] = 1'b1;
        next_sr[`CEL_SR_EM] = 1'b1;
      end
      EV_NONE: begin
        next_sr = sr;
      end
    endcase
  end

  // ********************
  // bus handshake
  // ********************
  // one wait state: read data is registered before waitrequest drops
  logic busAck, busRd, busWr;
  assign avs_waitrequest = (avs_read | avs_write) & ~busAck;
  assign busWr = avs_write & busAck;
  assign busRd = avs_read & ~busAck;
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) busAck <= 1'b0;
    else busAck <= (avs_read | avs_write) & ~busAck;
  end

  logic [4:0] saveIdx;
  assign saveIdx = avs_address - `CEL_REG_SAVE0;
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) avs_readdata <= 32'h0000_0000;
    else if (busRd) begin
      if (avs_address == `CEL_REG_STATUS) avs_readdata <= sr;
      else if (avs_address == `CEL_REG_VBASE) avs_readdata <= vectorBase;
      else if (avs_address == `CEL_REG_FVADDR) avs_readdata <= faultVaddr;
      else if (avs_address == `CEL_REG_FPAGE) avs_readdata <= faultPage;
      else if (avs_address >= `CEL_REG_SAVE0 && avs_address <= `CEL_REG_LAST) begin
        avs_readdata <= saveIdx[0] ? savedReturn[saveIdx[3:1]] : savedStatus[saveIdx[3:1]];
      end else avs_readdata <= 32'h0000_0000;
    end
  end

  // ********************
  // status and vector base
  // ********************
  // hardware entry wins over a software write in the same cycle
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) sr <= `CEL_SR_RESET;
    else if (take) sr <= next_sr;
    else if (debugReturn && sr[`CEL_SR_D]) sr <= savedStatus[`CEL_SLOT_DBG];
    else if (busWr && avs_address == `CEL_REG_STATUS) sr <= avs_writedata;
  end

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) vectorBase <= 32'h0000_0000;
    else if (busWr && avs_address == `CEL_REG_VBASE) vectorBase <= avs_writedata;
  end

  // ********************
  // save registers
  // ********************
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      for (int i = 0; i < `CEL_SLOTS; i++) begin
        savedStatus[i] <= 32'h0000_0000;
        savedReturn[i] <= 32'h0000_0000;
      end
    end else if (take) begin
      savedStatus[slot] <= sr;
      savedReturn[slot] <= retAddr;
    end else if (busWr && avs_address >= `CEL_REG_SAVE0 && avs_address <= `CEL_REG_LAST) begin
      if (saveIdx[0]) savedReturn[saveIdx[3:1]] <= avs_writedata;
      else savedStatus[saveIdx[3:1]] <= avs_writedata;
    end
  end

  // ********************
  // translation fault record
  // ********************
  // bits below the page number other than the side flag are kept, so software tags survive
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      faultVaddr <= 32'h0000_0000;
      faultPage  <= 32'h0000_0000;
    end else if (take && faultRec) begin
      faultVaddr <= failVaddr;
      faultPage[31:`CEL_PG_LSB] <= failVaddr[31:`CEL_PG_LSB];
      if (kind != EV_DREAD && kind != EV_IADDR) faultPage[`CEL_PG_ISIDE] <= iSide;
    end else if (busWr) begin
      if (avs_address == `CEL_REG_FVADDR) faultVaddr <= avs_writedata;
      if (avs_address == `CEL_REG_FPAGE) faultPage <= avs_writedata;
    end
  end

  // ********************
  // redirect output
  // ********************
  // or-ing rather than adding saves an adder; software aligns the base to suit
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      redirValid <= 1'b0;
      redirAddr  <= 32'h0000_0000;
      entryCause <= EV_NONE;
    end else begin
      redirValid <= take || (debugReturn && sr[`CEL_SR_D]);
      entryCause <= kind;
      if (take) redirAddr <= vectorBase | (useOffset ? irqOffset : vecOff);
      else if (debugReturn && sr[`CEL_SR_D]) redirAddr <= savedReturn[`CEL_SLOT_DBG];
    end
  end

  // ********************
  // checks
  // ********************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstN);

  sequence intEntry_s;
    take && kind == EV_IRQ_LEVEL2;
  endsequence
  sequence l2Masks_s;
    sr[`CEL_SR_I2M] && sr[`CEL_SR_I1M] && sr[`CEL_SR_I0M] && mode == `CEL_MODE_L2;
  endsequence

  // most checks look at the registered outputs; several start from take and kind, and some read savedStatus, faultVaddr or faultPage
  dbus_vector_a: assert property (redirValid && entryCause == EV_DBUS |->
    redirAddr == ($past(vectorBase) | `CEL_VEC_DBUS)) else $error("data bus error vector wrong");
  nmi_serial_a: assert property (instrBoundary && nmiF && mode == `CEL_MODE_NMI |=>
    !(redirValid && entryCause == EV_NMI)) else $error("nmi taken during nmi handling");
  nmi_entry_a: assert property (take && kind == EV_NMI |=> mode == `CEL_MODE_NMI && sr[`CEL_SR_EM]
    && sr[`CEL_SR_GM] && redirAddr == ($past(vectorBase) | `CEL_VEC_NMI)) else $error("nmi entry wrong");
  int_block_a: assert property (instrBoundary && irqF[3] && (sr[`CEL_SR_GM] || sr[`CEL_SR_I3M]) |=>
    !(redirValid && entryCause == EV_IRQ_LEVEL3)) else $error("masked level 3 taken");
  l3_masks_a: assert property (take && kind == EV_IRQ_LEVEL3 |=> mode == `CEL_MODE_L3 && sr[`CEL_SR_I3M:`CEL_SR_I0M] == 4'hf
    && savedStatus[`CEL_SLOT_L3] == $past(sr)) else $error("level 3 entry wrong");
  l2_masks_a: assert property (intEntry_s |=> l2Masks_s)
    else $error("level 2 entry masks wrong");
  lvl0_entry_a: assert property (take && kind == EV_IRQ_LEVEL0 |=> mode == `CEL_MODE_L0 && sr[`CEL_SR_I0M]
    && sr[`CEL_SR_I3M:`CEL_SR_I1M] == $past(sr[`CEL_SR_I3M:`CEL_SR_I1M])) else $error("level 0 entry wrong");
  irq_or_a: assert property (redirValid && entryCause inside {EV_IRQ_LEVEL3, EV_IRQ_LEVEL2, EV_IRQ_LEVEL1, EV_IRQ_LEVEL0} |->
    redirAddr == ($past(vectorBase) | $past(irqOffset))) else $error("interrupt address not or-ed");
  unrec_turn_a: assert property (instrBoundary && dataBusErr && sr[`CEL_SR_EM] |=>
    redirValid && entryCause == EV_UNREC && redirAddr == ($past(vectorBase) | `CEL_VEC_UNREC))
    else $error("masked exception not unrecoverable");
  fault_rec_a: assert property (take && faultRec |=> faultVaddr == $past(failVaddr)
    && faultPage[31:`CEL_PG_LSB] == $past(failVaddr[31:`CEL_PG_LSB])) else $error("fault record wrong");
  imiss_side_a: assert property (take && kind == EV_IMISS |=> faultPage[`CEL_PG_ISIDE]
    && redirAddr == ($past(vectorBase) | `CEL_VEC_IMISS)) else $error("fetch miss record wrong");
  bkpt_debug_a: assert property (take && kind == EV_BKPT |=> sr[`CEL_SR_D] && sr[`CEL_SR_DM]
    && redirAddr == ($past(vectorBase) | `CEL_VEC_BKPT)) else $error("breakpoint did not enter debug");
  dret_resume_a: assert property (debugReturn && sr[`CEL_SR_D] && !take |=> redirValid
    && sr == $past(savedStatus[`CEL_SLOT_DBG]) && redirAddr == $past(savedReturn[`CEL_SLOT_DBG]))
    else $error("debug return did not resume");

endmodule // cel_exc_entry
`default_nettype wire

//--- bench/cel_far_side.sv
// model of the interrupt controller and the debug hardware
`timescale 1ns/10ps
`default_nettype none

module cel_far_side (
  // clock
  input  wire logic        ref_clk,
  // wishes of the bench
  input  wire logic [3:0]  lvlWant,
  input  wire logic        brkWant,
  // lines into the core
  output logic      [3:0]  irqLevel,
  output logic      [31:0] irqOffset,
  output logic             debugBreak
);
  initial begin
    irqLevel   = 4'h0;
    irqOffset  = 32'h0;
    debugBreak = 1'b0;
  end

  // offset changes with the request and stands while it is high
  always @(posedge ref_clk) begin
    irqLevel   <= lvlWant;
    debugBreak <= brkWant;
    if (lvlWant[3]) begin
      irqOffset <= 32'h0000_02c0;
    end else if (lvlWant[2]) begin
      irqOffset <= 32'h0000_0280;
    end else if (lvlWant[1]) begin
      irqOffset <= 32'h0000_0240;
    end else if (lvlWant[0]) begin
      irqOffset <= 32'h0000_0200;
    end else begin
      // no source is asking: the bus carries nothing meaningful
      irqOffset <= ~irqOffset;
    end
  end
endmodule // cel_far_side

`default_nettype wire

//--- bench/cel_exc_entry_bench.sv
// self-checking bench of the exception entry logic
`timescale 1ns/10ps
`default_nettype none
`include "cel_cfg.svh"

module cel_exc_entry_bench
  import cel_pkg::*;
;
  localparam logic [31:0] BASE  = 32'h8000_0240;
  localparam logic [7:0]  GMSET = 8'he1;
  localparam logic [7:0]  FLT   = 8'h8e;
  localparam logic [7:0]  ISD   = 8'h0c;
  logic        ref_clk, rst_n, avs_read, avs_write, avs_waitrequest, nmiReq, debugBreak, brkWant;
  logic        instrBoundary, dataBusErr, debugReturn, redirValid, got;
  logic [4:0]  avs_address;
  logic [3:0]  irqLevel, lvlWant;
  logic [7:0]  oldEvt, youngEvt;
  logic [31:0] avs_writedata, avs_readdata, irqOffset, offendPc, nextPc, failVaddr;
  logic [31:0] redirAddr, statusWord, rdq;
  cel_evt_t    entryCause;
  int          n_errors, num_checks, cyc;

  cel_exc_entry i_cel_exc_entry (.ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .nmiReq(nmiReq),
    .irqLevel(irqLevel), .debugBreak(debugBreak), .irqOffset(irqOffset),
    .instrBoundary(instrBoundary), .dataBusErr(dataBusErr), .oldEvt(oldEvt), .youngEvt(youngEvt),
    .offendPc(offendPc), .nextPc(nextPc), .failVaddr(failVaddr), .debugReturn(debugReturn),
    .redirValid(redirValid), .redirAddr(redirAddr), .entryCause(entryCause), .statusWord(statusWord));
  cel_far_side i_cel_far_side (.ref_clk(ref_clk), .lvlWant(lvlWant), .brkWant(brkWant),
    .irqLevel(irqLevel), .irqOffset(irqOffset), .debugBreak(debugBreak));

  // ********************
  // shared tasks
  // ********************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  function automatic logic [31:0] st(input logic [2:0] md, input logic [3:0] lm, input logic em,
                                     input logic gm, input logic dbg);
    logic [31:0] v;
    v = 32'h0;
    v[`CEL_SR_MODE_HI:`CEL_SR_MODE_LO] = md;
    v[`CEL_SR_I3M:`CEL_SR_I0M] = lm;
    v[`CEL_SR_EM] = em;
    v[`CEL_SR_GM] = gm;
    v[`CEL_SR_D] = dbg;
    v[`CEL_SR_DM] = dbg;
    return v;
  endfunction

  // request held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    // no local limit: only the bench timeout may end a wait
    do begin
      @(posedge ref_clk);
    end while (avs_waitrequest !== 1'b0);
    chk({31'h0, avs_waitrequest}, 32'h0, "bus answer");
    rdq = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [4:0] a);
    bus(1'b0, a, 32'h0);
  endtask

  task automatic waitr(input int lim);
    got = 1'b0;
    for (int i = 0; i < lim && !got; i++) begin
      @(posedge ref_clk);
      got = (redirValid === 1'b1);
    end
  endtask

  task automatic none();
    waitr(20);
    chk({31'h0, got}, 32'h0, "unexpected redirect");
  endtask

  task automatic entry(input logic [31:0] addr, input cel_evt_t c, input logic [31:0] s);
    waitr(40);
    chk({31'h0, got}, 32'h1, "redirect");
    chk(redirAddr, addr, "handler address");
    chk({27'h0, entryCause}, {27'h0, c}, "cause");
    chk(statusWord, s, "status word");
  endtask

  task automatic fire(input logic [7:0] o, input logic [7:0] y, input logic d);
    @(posedge ref_clk);
    oldEvt <= o;
    youngEvt <= y;
    dataBusErr <= d;
    @(posedge ref_clk);
    oldEvt <= 8'h0;
    youngEvt <= 8'h0;
    dataBusErr <= 1'b0;
  endtask

  // ********************
  // scenarios
  // ********************
  task automatic t_regs();
    rd(`CEL_REG_STATUS);
    chk(rdq, `CEL_SR_RESET, "status after reset");
    wr(5'h1f, 32'hffff_ffff);
    rd(5'h1f);
    chk(rdq, 32'h0, "unmapped index");
    wr(`CEL_REG_VBASE, BASE);
    rd(`CEL_REG_VBASE);
    chk(rdq, BASE, "vector base");
    $display("done registers");
  endtask

  task automatic t_levels();
    for (int k = 3; k >= 0; k--) begin
      wr(`CEL_REG_STATUS, 32'h0);
      lvlWant[k] <= 1'b1;
      entry(BASE | (32'h200 + 32'(k * 64)), cel_evt_t'(5'(8 - k)),
            st(3'(k + 2), 4'((5'h1 << (k + 1)) - 5'h1), 1'b0, 1'b0, 1'b0));
      rd(5'(14 - 2 * k));
      chk(rdq, 32'h0, "level saved status");
      rd(5'(15 - 2 * k));
      chk(rdq, nextPc, "level saved return");
      none();
      lvlWant <= 4'h0;
      repeat (8) @(posedge ref_clk);
    end
    wr(`CEL_REG_STATUS, st(3'h0, 4'h0, 1'b0, 1'b1, 1'b0));
    lvlWant[1] <= 1'b1;
    none();
    wr(`CEL_REG_STATUS, 32'h0);
    entry(BASE | 32'h240, EV_IRQ_LEVEL1, st(3'h3, 4'h3, 1'b0, 1'b0, 1'b0));
    lvlWant <= 4'h0;
    repeat (8) @(posedge ref_clk);
    $display("done levels");
  endtask

  task automatic t_excs();
    logic [31:0] vec [8];
    cel_evt_t    cs [8];
    vec = '{`CEL_VEC_IBUS, `CEL_VEC_IADDR, `CEL_VEC_IMISS, `CEL_VEC_IPROT, `CEL_VEC_BKPT,
            `CEL_VEC_ILL, `CEL_VEC_UNIMPL, `CEL_VEC_DREAD};
    cs = '{EV_IBUS, EV_IADDR, EV_IMISS, EV_IPROT, EV_BKPT, EV_ILL, EV_UNIMPL, EV_DREAD};
    for (int i = 0; i < 8; i++) begin
      wr(`CEL_REG_STATUS, 32'h0);
      offendPc <= 32'h0000_2000 + 32'(i * 4);
      failVaddr <= 32'h1234_5002 + 32'(i * 4096);
      fire(8'h1 << i, 8'h0, 1'b0);
      entry(BASE | vec[i], cs[i], st(3'h6, 4'h0, 1'b1, GMSET[i], i == 4));
      rd(i == 4 ? 5'h10 : `CEL_REG_SAVE0);
      chk(rdq, 32'h0, "saved status");
      rd(i == 4 ? 5'h11 : 5'h05);
      chk(rdq, offendPc, "saved return");
      if (FLT[i]) begin
        rd(`CEL_REG_FVADDR);
        chk(rdq, failVaddr, "fault address");
        rd(`CEL_REG_FPAGE);
        chk({10'h0, rdq[31:10]}, {10'h0, failVaddr[31:10]}, "fault page");
        if (ISD[i]) chk({31'h0, rdq[`CEL_PG_ISIDE]}, 32'h1, "instruction side");
      end
      if (i == 4) begin
        @(posedge ref_clk);
        debugReturn <= 1'b1;
        @(posedge ref_clk);
        debugReturn <= 1'b0;
        waitr(10);
        chk({31'h0, got}, 32'h1, "resume redirect");
        chk(redirAddr, offendPc, "resume address");
        chk(statusWord, 32'h0, "status after debug return");
      end
    end
    $display("done exceptions");
  endtask

  task automatic t_misc();
    wr(`CEL_REG_STATUS, 32'h0);
    fire(8'h20, 8'h01, 1'b0);
    entry(BASE | `CEL_VEC_ILL, EV_ILL, st(3'h6, 4'h0, 1'b1, 1'b1, 1'b0));
    fire(8'h40, 8'h0, 1'b0);
    entry(BASE | `CEL_VEC_UNREC, EV_UNREC, st(3'h6, 4'h0, 1'b1, 1'b1, 1'b0));
    fire(8'h0, 8'h0, 1'b1);
    entry(BASE | `CEL_VEC_UNREC, EV_UNREC, st(3'h6, 4'h0, 1'b1, 1'b1, 1'b0));
    wr(`CEL_REG_STATUS, 32'h0);
    fire(8'h0, 8'h0, 1'b1);
    entry(BASE | `CEL_VEC_DBUS, EV_DBUS, st(3'h6, 4'h0, 1'b1, 1'b1, 1'b0));
    rd(5'h05);
    chk(rdq, nextPc, "data bus error return");
    wr(`CEL_REG_STATUS, st(3'h0, 4'h0, 1'b0, 1'b1, 1'b0));
    nmiReq <= 1'b1;
    entry(BASE | `CEL_VEC_NMI, EV_NMI, st(3'h7, 4'h0, 1'b1, 1'b1, 1'b0));
    rd(5'h06);
    chk(rdq, st(3'h0, 4'h0, 1'b0, 1'b1, 1'b0), "nmi saved status");
    rd(5'h07);
    chk(rdq, nextPc, "nmi saved return");
    none();
    nmiReq <= 1'b0;
    // the filtered copy lags the pin; leaving mode 111 earlier would admit a second entry
    repeat (8) @(posedge ref_clk);
    wr(`CEL_REG_STATUS, 32'h0);
    brkWant <= 1'b1;
    entry(BASE | `CEL_VEC_BKPT, EV_BKPT, st(3'h6, 4'h0, 1'b1, 1'b0, 1'b1));
    none();
    brkWant <= 1'b0;
    $display("done mixed events");
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // a hang is cut short well past the expected run length
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      report_and_stop();
    end
  end

  initial begin
    {n_errors, num_checks, cyc} = '0;
    {rst_n, avs_read, avs_write, nmiReq, dataBusErr, debugReturn, brkWant} = '0;
    {avs_address, lvlWant, oldEvt, youngEvt, avs_writedata} = '0;
    instrBoundary = 1'b1;
    offendPc = 32'h0000_1000;
    nextPc = 32'h0000_1004;
    failVaddr = 32'h0;
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    t_regs();
    t_levels();
    t_excs();
    t_misc();
    report_and_stop();
  end
endmodule // cel_exc_entry_bench

`default_nettype wire
